// ===== core/pcrc_pkg.sv
// Function
// - Polynomials of order up to 32
// - Length taken from control two bits 4:0
// - Set term bit enables XOR at that stage
// - Zero-order term always XORed, no storage
// - Highest-order term always used, implicit
// - Shift direction selectable per data word
// - Word width and length set independently
// - Selectable interrupt cause, FIFO before engine
// - Length field holds length minus one
// - Width field holds width minus one
// - One means LSB first, zero MSB first
// - Cause: FIFO empty or shift complete
package pcrc_pkg;

  // Register byte offsets
  localparam logic [5:0] PCRC_OFS_CTRL1 = 6'h00;
  localparam logic [5:0] PCRC_OFS_CTRL2 = 6'h04;
  localparam logic [5:0] PCRC_OFS_TERML = 6'h08;
  localparam logic [5:0] PCRC_OFS_TERMH = 6'h0C;
  localparam logic [5:0] PCRC_OFS_DATA = 6'h10;
  localparam logic [5:0] PCRC_OFS_RESULT = 6'h14;
  localparam logic [5:0] PCRC_OFS_IRQ_STAT = 6'h18;
  localparam logic [5:0] PCRC_OFS_IRQ_CLR = 6'h1C;
  localparam logic [5:0] PCRC_OFS_IRQ_EN = 6'h20;

  // Control one field positions
  localparam int PCRC_B_ENABLE = 15;
  localparam int PCRC_B_FULL = 7;
  localparam int PCRC_B_EMPTY = 6;
  localparam int PCRC_B_IRQSEL = 5;
  localparam int PCRC_B_GO = 4;
  localparam int PCRC_B_LSBF = 3;
  localparam int PCRC_B_VCNT_LO = 8;
  // Control two field positions
  localparam int PCRC_B_WWIDTH_LO = 8;
  localparam int PCRC_B_PLEN_LO = 0;

  // FIFO geometry
  localparam int PCRC_FIFO_DEPTH = 16;
  localparam logic [4:0] PCRC_FIFO_LIM_SHORT = 5'h10;
  localparam logic [4:0] PCRC_FIFO_LIM_LONG = 5'h08;
  localparam logic [4:0] PCRC_PLEN_SHORT_MAX = 5'h07;

  // Reset values
  localparam logic [31:0] PCRC_RST_WORD = 32'h00000000;
  localparam logic [4:0] PCRC_RST_FIELD = 5'h00;

  // Unmapped read value
  localparam logic [31:0] PCRC_UNMAPPED = 32'h00000000;

  // Configuration carrier
  typedef struct packed {
    logic enable;
    logic irq_cause_sel;
    logic go;
    logic lsb_first_sel;
    logic [4:0] word_width_sel;
    logic [4:0] poly_length_sel;
  } pcrc_cfg_s;

  // Engine states
  typedef enum logic {PCRC_IDLE, PCRC_SHIFT} pcrc_state_e;

endpackage : pcrc_pkg

// ===== core/pcrc_top.sv
`timescale 1ns/1ns
module pcrc_top
  import pcrc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  pcrc_cfg_s cfg_r, cfg_nxt;
  logic [31:0] terms_r, terms_nxt;
  logic [31:0] result_r, result_nxt;
  logic [31:0] shreg_r, shreg_nxt;
  logic [5:0] bits_r, bits_nxt;
  pcrc_state_e state_r, state_nxt;
  logic [31:0] fifo_mem [PCRC_FIFO_DEPTH];
  logic [3:0] wptr_r, wptr_nxt;
  logic [3:0] rptr_r, rptr_nxt;
  logic [4:0] count_r, count_nxt;
  logic ack_r, ack_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic stat_r, stat_nxt;
  logic irq_en_r, irq_en_nxt;
  logic irq_r, irq_nxt;

  logic req;
  logic acc;
  logic wr_acc;
  logic [31:0] bmask;
  logic [4:0] fifo_lim;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic pop;
  logic [31:0] len_mask;
  logic [31:0] poly;
  logic data_bit;
  logic fb;
  logic [31:0] crc_step;
  logic [31:0] word_in;
  logic ev;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Byte enable mask
  for (genvar g = 0; g < 4; g++) begin : g_bmask
    assign bmask[g*8 +: 8] = {8{avs_byteenable[g]}};
  end

  assign req = avs_read | avs_write;
  // Data writes stall while the FIFO is full
  assign acc = req && !ack_r && !(avs_write && avs_address == PCRC_OFS_DATA && fifo_full);
  // Writes take effect at the edge where waitrequest is low
  assign wr_acc = ack_r && avs_write;
  assign push = wr_acc && avs_address == PCRC_OFS_DATA && cfg_r.enable;

  // Read mux and acknowledge
  always_comb begin
    ack_nxt = acc;
    wait_nxt = !acc; // Low only in the accept cycle
    rdata_nxt = rdata_r;
    if (acc && avs_read) begin
      unique case (avs_address)
        PCRC_OFS_CTRL1: begin
          rdata_nxt = PCRC_RST_WORD;
          rdata_nxt[PCRC_B_ENABLE] = cfg_r.enable;
          rdata_nxt[PCRC_B_VCNT_LO +: 5] = count_r;
          rdata_nxt[PCRC_B_FULL] = fifo_full;
          rdata_nxt[PCRC_B_EMPTY] = fifo_empty;
          rdata_nxt[PCRC_B_IRQSEL] = cfg_r.irq_cause_sel;
          rdata_nxt[PCRC_B_GO] = cfg_r.go;
          rdata_nxt[PCRC_B_LSBF] = cfg_r.lsb_first_sel;
        end
        PCRC_OFS_CTRL2: begin
          rdata_nxt = PCRC_RST_WORD;
          rdata_nxt[PCRC_B_WWIDTH_LO +: 5] = cfg_r.word_width_sel;
          rdata_nxt[PCRC_B_PLEN_LO +: 5] = cfg_r.poly_length_sel;
        end
        PCRC_OFS_TERML: rdata_nxt = {16'h0000, terms_r[15:1], 1'b0};
        PCRC_OFS_TERMH: rdata_nxt = {16'h0000, terms_r[31:16]};
        PCRC_OFS_RESULT: rdata_nxt = result_r;
        PCRC_OFS_IRQ_STAT: rdata_nxt = {31'h00000000, stat_r};
        PCRC_OFS_IRQ_EN: rdata_nxt = {31'h00000000, irq_en_r};
        default: rdata_nxt = PCRC_UNMAPPED;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= PCRC_RST_WORD;
    end else begin
      ack_r <= ack_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Bus outputs straight from their registers
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Software writes with byte enables
  always_comb begin
    logic [31:0] merged;
    merged = PCRC_RST_WORD;
    cfg_nxt = cfg_r;
    terms_nxt = terms_r;
    irq_en_nxt = irq_en_r;
    if (wr_acc) begin
      unique case (avs_address)
        PCRC_OFS_CTRL1: begin
          merged = avs_writedata & bmask;
          if (avs_byteenable[1]) begin
            cfg_nxt.enable = merged[PCRC_B_ENABLE];
          end
          if (avs_byteenable[0]) begin
            cfg_nxt.irq_cause_sel = merged[PCRC_B_IRQSEL];
            cfg_nxt.go = merged[PCRC_B_GO];
            cfg_nxt.lsb_first_sel = merged[PCRC_B_LSBF];
          end
        end
        PCRC_OFS_CTRL2: begin
          if (avs_byteenable[1]) begin
            cfg_nxt.word_width_sel = avs_writedata[PCRC_B_WWIDTH_LO +: 5];
          end
          if (avs_byteenable[0]) begin
            cfg_nxt.poly_length_sel = avs_writedata[PCRC_B_PLEN_LO +: 5];
          end
        end
        PCRC_OFS_TERML: begin
          merged = (avs_writedata & bmask) | (terms_r & ~bmask);
          terms_nxt[15:1] = merged[15:1];
        end
        PCRC_OFS_TERMH: begin
          merged = ({avs_writedata[15:0], 16'h0000} & {bmask[15:0], 16'h0000})
                 | (terms_r & ~{bmask[15:0], 16'h0000});
          terms_nxt[31:16] = merged[31:16];
        end
        PCRC_OFS_IRQ_EN: begin
          if (avs_byteenable[0]) begin
            irq_en_nxt = avs_writedata[0];
          end
        end
        default: merged = PCRC_RST_WORD;
      endcase
    end
    terms_nxt[0] = 1'b0;
  end

  // Configuration storage
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r <= '0;
      terms_r <= PCRC_RST_WORD;
      irq_en_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      terms_r <= terms_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data FIFO

  // Depth halves for polynomials longer than eight
  assign fifo_lim = (cfg_r.poly_length_sel > PCRC_PLEN_SHORT_MAX) ? PCRC_FIFO_LIM_LONG
                                                                 : PCRC_FIFO_LIM_SHORT;
  assign fifo_full = count_r >= fifo_lim;
  assign fifo_empty = count_r == PCRC_RST_FIELD;
  assign pop = cfg_r.enable && cfg_r.go && !fifo_empty && state_r == PCRC_IDLE;

  // Pointer and count update; disable clears them
  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    count_nxt = count_r;
    if (!cfg_r.enable) begin
      wptr_nxt = 4'h0;
      rptr_nxt = 4'h0;
      count_nxt = PCRC_RST_FIELD;
    end else begin
      if (push) begin
        wptr_nxt = wptr_r + 4'h1;
      end
      if (pop) begin
        rptr_nxt = rptr_r + 4'h1;
      end
      count_nxt = count_r + {4'h0, push} - {4'h0, pop};
    end
  end

  // Pointer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_r <= 4'h0;
      rptr_r <= 4'h0;
      count_r <= PCRC_RST_FIELD;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wptr_r] <= avs_writedata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine

  // Mask of the active stages; length field is length minus one
  assign len_mask = 32'hFFFFFFFF >> (5'd31 - cfg_r.poly_length_sel);
  // Stage zero always fed back, top term implied by the feedback tap
  assign poly = {terms_r[31:1], 1'b1} & len_mask;
  // LSB first shifts right, MSB first word is left aligned
  assign data_bit = cfg_r.lsb_first_sel ? shreg_r[0] : shreg_r[31];
  assign fb = result_r[cfg_r.poly_length_sel] ^ data_bit;
  assign crc_step = ((result_r << 1) & len_mask) ^ (fb ? poly : PCRC_RST_WORD);
  // Word aligned for the chosen direction; width field is width minus one
  assign word_in = cfg_r.lsb_first_sel ? fifo_mem[rptr_r]
                 : fifo_mem[rptr_r] << (5'd31 - cfg_r.word_width_sel);

  // Engine next state
  always_comb begin
    state_nxt = state_r;
    shreg_nxt = shreg_r;
    bits_nxt = bits_r;
    result_nxt = result_r;
    ev = 1'b0;
    if (!cfg_r.enable) begin
      state_nxt = PCRC_IDLE;
      shreg_nxt = PCRC_RST_WORD;
      bits_nxt = 6'h00;
      result_nxt = PCRC_RST_WORD;
    end else begin
      unique case (state_r)
        PCRC_IDLE: begin
          if (wr_acc && avs_address == PCRC_OFS_RESULT) begin
            result_nxt = avs_writedata & len_mask;
          end
          if (pop) begin
            state_nxt = PCRC_SHIFT;
            shreg_nxt = word_in;
            bits_nxt = {1'b0, cfg_r.word_width_sel} + 6'h01;
            // Last word leaves the FIFO and starts shifting
            ev = cfg_r.irq_cause_sel && count_r == 5'h01 && !push;
          end
        end
        PCRC_SHIFT: begin
          result_nxt = crc_step;
          shreg_nxt = cfg_r.lsb_first_sel ? (shreg_r >> 1) : (shreg_r << 1);
          bits_nxt = bits_r - 6'h01;
          if (bits_r == 6'h01) begin
            state_nxt = PCRC_IDLE;
            // Result ready with nothing left to shift
            ev = !cfg_r.irq_cause_sel && fifo_empty && !push;
          end
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= PCRC_IDLE;
      shreg_r <= PCRC_RST_WORD;
      bits_r <= 6'h00;
      result_r <= PCRC_RST_WORD;
    end else begin
      state_r <= state_nxt;
      shreg_r <= shreg_nxt;
      bits_r <= bits_nxt;
      result_r <= result_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt

  // Sticky status; a new event wins over a clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_acc && avs_address == PCRC_OFS_IRQ_CLR && avs_byteenable[0] && avs_writedata[0]) begin
      stat_nxt = 1'b0;
    end
    if (ev) begin
      stat_nxt = 1'b1;
    end
    irq_nxt = stat_nxt && irq_en_nxt;
  end

  // Interrupt registers
  always_ff @(posedge clk) begin
    if (reset) begin
      stat_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;

endmodule : pcrc_top

// ===== sim/pcrc_top_chk.sv
`timescale 1ns/1ns
module pcrc_top_chk
  import pcrc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Read taken while the slave is not answering
  sequence s_rd_taken;
    avs_read && avs_waitrequest;
  endsequence
  // Accepted write that masks the interrupt
  sequence s_mask;
    avs_write && !avs_waitrequest && avs_address == PCRC_OFS_IRQ_EN &&
      avs_byteenable[0] && !avs_writedata[0];
  endsequence
  chk_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  chk_read_answer: assert property (s_rd_taken |=> !avs_waitrequest)
    else $error("read not answered");
  chk_write_answer: assert property
    (avs_write && avs_waitrequest && avs_address != PCRC_OFS_DATA |=> !avs_waitrequest)
    else $error("write not answered");
  chk_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved");
  chk_unmapped_zero: assert property
    (s_rd_taken ##0 avs_address == 6'h24 |=> avs_readdata == PCRC_UNMAPPED)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property (s_mask |-> ##2 !irq)
    else $error("irq high while masked");
  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> avs_waitrequest && !irq && avs_readdata == 32'h00000000)
    else $error("outputs not quiet in reset");
endmodule : pcrc_top_chk
bind pcrc_top pcrc_top_chk u_pcrc_top_chk (.clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import pcrc_pkg::*;
;
  // Stimulus and observed outputs
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [31:0] rd;
  logic [31:0] exp_crc;
  int failures = 0;
  int checked = 0;

  pcrc_top u_pcrc_top (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  always #2 clk = ~clk;

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Read a register and compare
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rdc

  // Poll the event status bit, bounded
  task automatic wait_status;
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, PCRC_OFS_IRQ_STAT, 32'h00000000);
      if (rd[0] === 1'b1) break;
    end
    check(rd, 32'h00000001);
  endtask : wait_status

  // Bit-serial reference: feedback from the top stage, X0 and XN implied
  function automatic logic [31:0] crc_model(logic [31:0] c, logic [31:0] d, int w, int n,
    logic [31:0] t, logic lsb);
    logic [31:0] mask;
    logic b;
    mask = (n == 32) ? 32'hFFFFFFFF : ((32'h00000001 << n) - 32'h00000001);
    for (int i = 0; i < w; i++) begin
      b = lsb ? d[i] : d[w-1-i];
      c = ((c << 1) & mask) ^ ((c[n-1] ^ b) ? ((t | 32'h00000001) & mask) : 32'h00000000);
    end
    return c;
  endfunction : crc_model

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped place
  task automatic t_reset;
    check({31'h0, irq}, 32'h00000000);
    rdc(PCRC_OFS_CTRL1, 32'h00000040);
    rdc(PCRC_OFS_CTRL2, 32'h00000000);
    rdc(PCRC_OFS_TERML, 32'h00000000);
    rdc(PCRC_OFS_RESULT, 32'h00000000);
    rdc(6'h24, 32'h00000000);
    $display("test reset done");
  endtask : t_reset

  // 16-bit polynomial, MSB first, event on result ready, masked then unmasked
  task automatic t_crc16;
    bus(1'b1, PCRC_OFS_CTRL1, 32'h00008000);
    bus(1'b1, PCRC_OFS_CTRL2, 32'h00000F0F);
    rdc(PCRC_OFS_CTRL2, 32'h00000F0F);
    bus(1'b1, PCRC_OFS_TERML, 32'h00001021);
    rdc(PCRC_OFS_TERML, 32'h00001020);
    bus(1'b1, PCRC_OFS_RESULT, 32'h0000FFFF);
    bus(1'b1, PCRC_OFS_DATA, 32'h00001234);
    bus(1'b1, PCRC_OFS_DATA, 32'h00005678);
    rdc(PCRC_OFS_CTRL1, 32'h00008200);
    bus(1'b1, PCRC_OFS_CTRL1, 32'h00008010);
    wait_status();
    exp_crc = crc_model(32'h0000FFFF, 32'h00001234, 16, 16, 32'h00001021, 1'b0);
    exp_crc = crc_model(exp_crc, 32'h00005678, 16, 16, 32'h00001021, 1'b0);
    rdc(PCRC_OFS_RESULT, exp_crc);
    check({31'h0, irq}, 32'h00000000);
    bus(1'b1, PCRC_OFS_IRQ_EN, 32'h00000001);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h00000001);
    bus(1'b1, PCRC_OFS_IRQ_CLR, 32'h00000001);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h00000000);
    rdc(PCRC_OFS_IRQ_STAT, 32'h00000000);
    $display("test crc16 done");
  endtask : t_crc16

  // 32-bit polynomial, 8-bit words LSB first, event on FIFO empty
  task automatic t_crc32;
    bus(1'b1, PCRC_OFS_CTRL1, 32'h00000000);
    rdc(PCRC_OFS_RESULT, 32'h00000000);
    bus(1'b1, PCRC_OFS_CTRL2, 32'h0000071F);
    bus(1'b1, PCRC_OFS_TERMH, 32'h000004C1);
    bus(1'b1, PCRC_OFS_TERML, 32'h00001DB7);
    bus(1'b1, PCRC_OFS_CTRL1, 32'h00008008);
    bus(1'b1, PCRC_OFS_RESULT, 32'hFFFFFFFF);
    bus(1'b1, PCRC_OFS_DATA, 32'h000000A5);
    bus(1'b1, PCRC_OFS_DATA, 32'h0000003C);
    bus(1'b1, PCRC_OFS_CTRL1, 32'h00008038);
    wait_status();
    check({31'h0, irq}, 32'h00000001);
    repeat (20) @(posedge clk);
    exp_crc = crc_model(32'hFFFFFFFF, 32'h000000A5, 8, 32, 32'h04C11DB7, 1'b1);
    exp_crc = crc_model(exp_crc, 32'h0000003C, 8, 32, 32'h04C11DB7, 1'b1);
    rdc(PCRC_OFS_RESULT, exp_crc);
    bus(1'b1, PCRC_OFS_IRQ_EN, 32'h00000000);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h00000000);
    $display("test crc32 done");
  endtask : t_crc32

  // Long polynomial limits the FIFO to eight words; disable empties it
  task automatic t_full;
    bus(1'b1, PCRC_OFS_CTRL1, 32'h00008000);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, PCRC_OFS_DATA, 32'h00000011);
    end
    rdc(PCRC_OFS_CTRL1, 32'h00008880);
    bus(1'b1, PCRC_OFS_CTRL1, 32'h00000000);
    rdc(PCRC_OFS_CTRL1, 32'h00000040);
    $display("test full done");
  endtask : t_full

  // Counts and verdict
  task automatic complete_run;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_crc16();
    t_crc32();
    t_full();
    complete_run();
  end

  // Watchdog
  initial begin
    #80000;
    failures++;
    complete_run();
  end
endmodule : tb_top
